//--- include/sscp_pkg.sv
// Package for the start synchronisation and cyclic pipeline block.
// Assumes a single 100 MHz system clock and a plain register port with word indices.
package sscp_pkg;

  // Register indices on the plain register port.
  localparam logic [7:0] ADDR_GLOBAL_SETTINGS  = 8'h00;
  localparam logic [7:0] ADDR_TRIGGER_SETTINGS = 8'h02;
  localparam logic [7:0] ADDR_GEARING_FACTOR   = 8'h12;
  localparam logic [7:0] ADDR_POS_COMPARE      = 8'h32;
  localparam logic [7:0] ADDR_TARGET_POSITION  = 8'h37;
  localparam logic [7:0] ADDR_STAGE_FIRST      = 8'h38;
  localparam logic [7:0] ADDR_STAGE_LAST       = 8'h3F;
  localparam logic [7:0] ADDR_PIPE_CONTROL     = 8'h40;
  localparam logic [7:0] ADDR_SYNC_STATUS      = 8'h41;

  // Field positions in trigger_settings.
  localparam int TS_BUSY_EN_POS    = 0;
  localparam int TS_START_POL_POS  = 1;
  localparam int TS_HOLD_LSB       = 8;
  localparam int TS_HOLD_W         = 8;
  localparam int TS_TIMER_LSB      = 16;
  localparam int TS_TIMER_W        = 16;

  // Field positions in the pipeline control register.
  localparam int PC_EN_LSB     = 0;
  localparam int PC_EN_W       = 4;
  localparam int PC_CYC_LSB    = 4;
  localparam int PC_WB_LSB     = 8;
  localparam int PC_WB_W       = 3;

  // Reset values.
  localparam logic [31:0] TRIGGER_SETTINGS_RST = 32'h0000_0000;
  localparam logic [31:0] PIPE_CONTROL_RST     = 32'h0000_0000;

  // Sync line state machine.
  typedef enum logic [3:0] {
    SS_IDLE   = 4'b0001,
    SS_BUSY   = 4'b0010,
    SS_WAIT   = 4'b0100,
    SS_STRONG = 4'b1000
  } sscp_sync_state_type;

endpackage

//--- hw/sscp_map.sv
// Pipeline mapping: first stage index and depth minus one (last stage offset) for each of the four targets.
// Assumes a four-bit target enable; targets ordered position, compare, gearing, global.
`timescale 1ns/10ps
module sscp_map (
  input  wire logic [3:0]  i_enable,
  output logic      [11:0] o_base,
  output logic      [11:0] o_depth
);

  // Walk enabled targets in order and share eight stages among them.
  always_comb
  begin
    logic [3:0] cnt;
    logic [3:0] dep_big;
    logic [3:0] dep_last;
    logic [3:0] pos;
    logic [3:0] idx;
    cnt = 4'(i_enable[0]) + 4'(i_enable[1]) + 4'(i_enable[2]) + 4'(i_enable[3]);
    dep_big = (cnt == 4'h1) ? 4'h8 : (cnt == 4'h2) ? 4'h4 : (cnt == 4'h3) ? 4'h3 : 4'h2;
    dep_last = (cnt == 4'h3) ? 4'h2 : dep_big;
    pos = 4'h0;
    idx = 4'h0;
    o_base = 12'h000;
    o_depth = 12'h000;
    for (int t = 0; t < 4; t++)
    begin
      if (i_enable[t])
      begin
        idx = idx + 4'h1;
        o_base[t*3 +: 3] = pos[2:0];
        o_depth[t*3 +: 3] = (idx == cnt) ? 3'(dep_last - 4'h1) : 3'(dep_big - 4'h1);
        pos = pos + ((idx == cnt) ? dep_last : dep_big);
      end
    end
  end

endmodule

//--- hw/sscp_top.sv
// Start synchronisation over a shared line, plus the cyclic parameter pipeline.
// Assumes register strobes are one cycle long and never overlap.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
// Functional notes
// [R1] Cyclic mode copies each target's value back into its own pipeline.
// [R2] Write-back may land on any stage of the pipeline, shortening the cycle.
// [R3] Write-back routing follows the select field and the active mapping.
// [R4] Each pipeline is cyclic or not; four targets give two stages each.
// [R5] Busy with sync enabled: drive the line strongly at inactive polarity.
// [R6] After own internal start, release the line to an input.
// [R7] While released, weakly drive the active polarity onto the line.
// [R8] Line active means all ready; then drive active strongly for hold cycles.
// [R9] After the strong phase, return to busy until next start.
// [R10] Software sets the sync enable bit in trigger_settings to use this.
// [R11] On internal start each enabled target loads from its mapped stage.
// [R12] Eight stage registers split into up to four segments.
// [R13] Four-bit enable picks targets; depths eight, four, three or two.
// [R14] Write-back takes the pre-update target value in the transfer cycle.
module sscp_top #(
  parameter int DATA_W = 32
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  input  wire logic              i_start_req,
  input  wire logic              i_sync_in,
  output logic                   o_sync_out,
  output logic                   o_sync_oe_b,
  output logic                   o_sync_weak,
  output logic                   o_start_pulse
);

  // Elaboration-time refusal of stage widths that the 32-bit port cannot carry.
  if (DATA_W < 1 || DATA_W > 32)
  begin : gen_bad_width
    $error("DATA_W must be 1 to 32");
  end

  logic [DATA_W-1:0] stage_q [8];
  logic [DATA_W-1:0] tgt_q   [4];
  logic [31:0]       trig_q;
  logic [31:0]       pctl_q;
  logic [11:0]       base;
  logic [11:0]       depth;
  logic [15:0]       timer_q;
  logic [7:0]        hold_q;
  logic              start;
  logic              busy_en;
  logic              act_pol;
  sscp_pkg::sscp_sync_state_type state_q;

  assign busy_en = trig_q[sscp_pkg::TS_BUSY_EN_POS];
  assign act_pol = trig_q[sscp_pkg::TS_START_POL_POS];

  ////////////////////////////////////////////////////////////////////////////////
  // Mapping of enabled targets to stage segments.
  sscp_map u_map (
    .i_enable (pctl_q[sscp_pkg::PC_EN_LSB +: sscp_pkg::PC_EN_W]),
    .o_base   (base),
    .o_depth  (depth)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      trig_q <= sscp_pkg::TRIGGER_SETTINGS_RST;
      pctl_q <= sscp_pkg::PIPE_CONTROL_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == sscp_pkg::ADDR_TRIGGER_SETTINGS)
        trig_q <= i_wdata; // R10
      if (i_addr == sscp_pkg::ADDR_PIPE_CONTROL)
        pctl_q <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal start: a request arms the start timer; expiry makes the start pulse.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      timer_q <= 16'h0000;
    else if (i_start_req && timer_q == 16'h0000)
      timer_q <= trig_q[sscp_pkg::TS_TIMER_LSB +: sscp_pkg::TS_TIMER_W] + 16'h0001;
    else if (timer_q != 16'h0000)
      timer_q <= timer_q - 16'h0001;
  end

  assign start = (timer_q == 16'h0001);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      o_start_pulse <= 1'b0;
    else
      o_start_pulse <= start;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stage and target registers, with transfer and cyclic write-back on start.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      for (int s = 0; s < 8; s++)
        stage_q[s] <= '0;
      for (int t = 0; t < 4; t++)
        tgt_q[t] <= '0;
    end
    else
    begin
      if (i_wr && i_addr >= sscp_pkg::ADDR_STAGE_FIRST && i_addr <= sscp_pkg::ADDR_STAGE_LAST)
        stage_q[i_addr[2:0]] <= i_wdata[DATA_W-1:0]; // R12
      if (i_wr && i_addr == sscp_pkg::ADDR_TARGET_POSITION)
        tgt_q[0] <= i_wdata[DATA_W-1:0];
      if (i_wr && i_addr == sscp_pkg::ADDR_POS_COMPARE)
        tgt_q[1] <= i_wdata[DATA_W-1:0];
      if (i_wr && i_addr == sscp_pkg::ADDR_GEARING_FACTOR)
        tgt_q[2] <= i_wdata[DATA_W-1:0];
      if (i_wr && i_addr == sscp_pkg::ADDR_GLOBAL_SETTINGS)
        tgt_q[3] <= i_wdata[DATA_W-1:0];
      if (start)
      begin
        for (int t = 0; t < 4; t++)
        begin
          if (pctl_q[sscp_pkg::PC_EN_LSB + t]) // R13
          begin
            tgt_q[t] <= stage_q[base[t*3 +: 3]]; // R11
            // Offset in segment, clipped to depth, so write-back stays in own pipeline.
            if (pctl_q[sscp_pkg::PC_CYC_LSB + t]) // R4
              stage_q[3'(base[t*3 +: 3] + ((pctl_q[sscp_pkg::PC_WB_LSB +: 3] > depth[t*3 +: 3])
                ? depth[t*3 +: 3] : pctl_q[sscp_pkg::PC_WB_LSB +: 3]))] <= tgt_q[t]; // R1 R2 R3 R14
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared start line handling.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      state_q <= sscp_pkg::SS_IDLE;
      hold_q  <= 8'h00;
    end
    else if (!busy_en)
      state_q <= sscp_pkg::SS_IDLE;
    else
    begin
      case (state_q)
        sscp_pkg::SS_IDLE:
          state_q <= sscp_pkg::SS_BUSY;
        sscp_pkg::SS_BUSY:
          if (start)
            state_q <= sscp_pkg::SS_WAIT; // R6
        sscp_pkg::SS_WAIT:
          if (i_sync_in == act_pol)
          begin
            state_q <= sscp_pkg::SS_STRONG; // R8
            hold_q  <= trig_q[sscp_pkg::TS_HOLD_LSB +: sscp_pkg::TS_HOLD_W];
          end
        sscp_pkg::SS_STRONG:
          if (hold_q <= 8'h01)
            state_q <= sscp_pkg::SS_BUSY; // R9
          else
            hold_q <= hold_q - 8'h01;
        default:
          state_q <= sscp_pkg::SS_IDLE;
      endcase
    end
  end

  // Pin drive follows the state: strong inactive, weak active, strong active.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      o_sync_out  <= 1'b0;
      o_sync_oe_b <= 1'b1;
      o_sync_weak <= 1'b0;
    end
    else
    begin
      o_sync_out  <= (state_q == sscp_pkg::SS_BUSY) ? !act_pol : act_pol; // R5
      o_sync_oe_b <= !(state_q == sscp_pkg::SS_BUSY || state_q == sscp_pkg::SS_STRONG);
      o_sync_weak <= (state_q == sscp_pkg::SS_WAIT); // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port, data in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
    begin
      o_rdata <= 32'h0000_0000;
      if (i_addr >= sscp_pkg::ADDR_STAGE_FIRST && i_addr <= sscp_pkg::ADDR_STAGE_LAST)
        o_rdata <= 32'(stage_q[i_addr[2:0]]);
      else
        case (i_addr)
          sscp_pkg::ADDR_TRIGGER_SETTINGS: o_rdata <= trig_q;
          sscp_pkg::ADDR_PIPE_CONTROL:     o_rdata <= pctl_q;
          sscp_pkg::ADDR_SYNC_STATUS:      o_rdata <= {28'h0000000, state_q};
          sscp_pkg::ADDR_TARGET_POSITION:  o_rdata <= 32'(tgt_q[0]);
          sscp_pkg::ADDR_POS_COMPARE:      o_rdata <= 32'(tgt_q[1]);
          sscp_pkg::ADDR_GEARING_FACTOR:   o_rdata <= 32'(tgt_q[2]);
          sscp_pkg::ADDR_GLOBAL_SETTINGS:  o_rdata <= 32'(tgt_q[3]);
          default:                         o_rdata <= 32'h0000_0000;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  busy_drive_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_q == sscp_pkg::SS_BUSY |=> !o_sync_oe_b && o_sync_out == !$past(act_pol)) // R5
    else $error("busy line not driven inactive");
  release_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_q == sscp_pkg::SS_BUSY && busy_en && start |=> state_q == sscp_pkg::SS_WAIT) // R6
    else $error("line not released on start");
  weak_drive_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_q == sscp_pkg::SS_WAIT |=> o_sync_weak && o_sync_oe_b) // R7
    else $error("weak drive missing");
  strong_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_q == sscp_pkg::SS_WAIT && busy_en && i_sync_in == act_pol
    |=> state_q == sscp_pkg::SS_STRONG) // R8
    else $error("active level not followed");
  back_busy_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_q == sscp_pkg::SS_STRONG && busy_en && hold_q <= 8'h01
    |=> state_q == sscp_pkg::SS_BUSY) // R9
    else $error("no return to busy");
  target_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    start && pctl_q[0] && !i_wr |=> tgt_q[0] == $past(stage_q[base[2:0]])) // R11
    else $error("target not loaded");
  start_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    start |=> o_start_pulse ##1 !o_start_pulse) // start pulse one cycle after start, for one cycle
    else $error("start pulse wrong");
  map_base_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    pctl_q[3:0] == 4'hF |-> base == 12'hD10) // R13
    else $error("four-way mapping wrong");

endmodule

//--- verif/sscp_peer.sv
// Model of one more controller sharing the start line.
// Assumes active-high start polarity and the same hold count as the block.
`timescale 1ns/10ps
module sscp_peer #(
  parameter int HOLD = 3
) (
  input  wire logic i_sys_clk,
  input  wire logic i_line,
  input  wire logic i_ready,
  output logic      o_drv,
  output logic      o_oe_b,
  output logic      o_weak
);
  int   cnt_q  = 0;
  logic done_q = 1'b0;
  // Seeing the line active while released starts the strong hold phase.
  always @(posedge i_sys_clk)
  begin
    if (cnt_q > 0)
    begin
      cnt_q  <= cnt_q - 1;
      done_q <= (cnt_q == 1);
    end
    else if (i_ready && !done_q && i_line)
    begin
      cnt_q <= HOLD;
    end
  end
  // Busy drives inactive strongly; ready releases and pulls active weakly.
  always_comb
  begin
    o_oe_b = !(cnt_q > 0 || !i_ready || done_q);
    o_drv  = (cnt_q > 0) || (i_ready && !done_q);
    o_weak = i_ready && !done_q && cnt_q == 0;
  end
endmodule

//--- verif/sscp_top_tb_top.sv
// Self-checking bench for the start sync and cyclic pipeline block.
// Assumes one 100 MHz clock and one peer controller on the shared line.
`timescale 1ns/10ps
module sscp_top_tb_top;
  logic        i_sys_clk;
  logic        i_rst_b     = 1'b0;
  logic [7:0]  i_addr      = 8'h00;
  logic [31:0] i_wdata     = 32'h0;
  logic        i_wr        = 1'b0;
  logic        i_rd        = 1'b0;
  logic        i_start_req = 1'b0;
  logic        ready       = 1'b0;
  logic        line;
  logic [31:0] o_rdata;
  logic        o_sync_out;
  logic        o_sync_oe_b;
  logic        o_sync_weak;
  logic        o_start_pulse;
  logic        p_drv;
  logic        p_oe_b;
  logic        p_weak;
  logic [31:0] rv;
  logic [7:0]  tgt [4];
  int          base [2][4];
  int          num_errors  = 0;
  int          cmp_count   = 0;
  int          n;

  sscp_top DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_start_req(i_start_req), .i_sync_in(line), .o_sync_out(o_sync_out),
    .o_sync_oe_b(o_sync_oe_b), .o_sync_weak(o_sync_weak), .o_start_pulse(o_start_pulse));
  sscp_peer #(.HOLD(3)) peer (.i_sys_clk(i_sys_clk), .i_line(line), .i_ready(ready),
    .o_drv(p_drv), .o_oe_b(p_oe_b), .o_weak(p_weak));

  // A strong driver wins; with no weak pull the line rests inactive.
  assign line = !o_sync_oe_b ? o_sync_out : !p_oe_b ? p_drv : (o_sync_weak | p_weak);

  // Clock generation.
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
  begin
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  // One-cycle register write, then one idle cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
    @(posedge i_sys_clk);
  end
  endtask

  // One-cycle register read; data sampled in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
  begin
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
    @(posedge i_sys_clk);
  end
  endtask

  // Requests an internal start and waits for its pulse.
  task automatic start;
  begin
    i_start_req <= 1'b1;
    @(posedge i_sys_clk);
    i_start_req <= 1'b0;
    n = 0;
    #1;
    while (o_start_pulse !== 1'b1 && n < 50)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check("start_pulse", {31'h0, o_start_pulse}, 32'h1);
    @(posedge i_sys_clk);
  end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
  begin
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial
  begin
    tgt = '{sscp_pkg::ADDR_TARGET_POSITION, sscp_pkg::ADDR_POS_COMPARE,
            sscp_pkg::ADDR_GEARING_FACTOR, sscp_pkg::ADDR_GLOBAL_SETTINGS};
    base = '{'{0, 2, 4, 6}, '{0, 3, 6, 0}};
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd(sscp_pkg::ADDR_TRIGGER_SETTINGS, rv);
    check("trig_rst", rv, sscp_pkg::TRIGGER_SETTINGS_RST);
    wr(sscp_pkg::ADDR_TRIGGER_SETTINGS, 32'h0000_0302);
    rd(sscp_pkg::ADDR_TRIGGER_SETTINGS, rv);
    check("trig_rw", rv, 32'h0000_0302);
    rd(8'h7F, rv);
    check("unmapped", rv, 32'h0);
    $display("test registers done");
    // Cyclic pipelines for two targets; an offset of seven is clipped to the last stage.
    wr(sscp_pkg::ADDR_PIPE_CONTROL, 32'h0000_0733);
    wr(sscp_pkg::ADDR_TARGET_POSITION, 32'hA0);
    wr(sscp_pkg::ADDR_POS_COMPARE, 32'hB0);
    for (int i = 0; i < 8; i++) wr(sscp_pkg::ADDR_STAGE_FIRST + 8'(i), 32'h10 + 32'(i));
    start();
    rd(sscp_pkg::ADDR_TARGET_POSITION, rv);
    check("pos_load", rv, 32'h10);
    rd(sscp_pkg::ADDR_POS_COMPARE, rv);
    check("cmp_load", rv, 32'h14);
    rd(sscp_pkg::ADDR_STAGE_FIRST + 8'h03, rv);
    check("pos_wback", rv, 32'hA0);
    rd(sscp_pkg::ADDR_STAGE_LAST, rv);
    check("cmp_wback", rv, 32'hB0);
    // One eight-stage pipeline written back at stage five, giving a six-stage cycle.
    wr(sscp_pkg::ADDR_PIPE_CONTROL, 32'h0000_0511);
    wr(sscp_pkg::ADDR_TARGET_POSITION, 32'hC0);
    start();
    rd(sscp_pkg::ADDR_STAGE_FIRST + 8'h05, rv);
    check("six_wback", rv, 32'hC0);
    rd(sscp_pkg::ADDR_TARGET_POSITION, rv);
    check("six_load", rv, 32'h10);
    $display("test cyclic done");
    // Non-cyclic mappings with four and with three targets.
    for (int c = 0; c < 2; c++)
    begin
      wr(sscp_pkg::ADDR_PIPE_CONTROL, c ? 32'h7 : 32'hF);
      for (int i = 0; i < 8; i++) wr(sscp_pkg::ADDR_STAGE_FIRST + 8'(i), 32'h20 + 32'(i));
      start();
      for (int t = 0; t < 4 - c; t++)
      begin
        rd(tgt[t], rv);
        check("map_load", rv, 32'h20 + 32'(base[c][t]));
      end
    end
    $display("test mapping done");
    // Shared line: busy, release, wait for the peer, strong hold, busy again.
    wr(sscp_pkg::ADDR_TRIGGER_SETTINGS, 32'h0002_0303);
    repeat (3) @(posedge i_sys_clk);
    #1;
    check("busy", {30'h0, o_sync_oe_b, o_sync_out}, 32'h0);
    @(posedge i_sys_clk);
    rd(sscp_pkg::ADDR_SYNC_STATUS, rv);
    check("status_busy", rv, 32'h0000_0002);
    start();
    #1;
    check("released", {29'h0, o_sync_oe_b, o_sync_weak, o_sync_out}, 32'h7);
    repeat (5) @(posedge i_sys_clk);
    #1;
    check("peer_busy", {29'h0, o_sync_oe_b, o_sync_weak, o_sync_out}, 32'h7);
    @(posedge i_sys_clk);
    ready <= 1'b1;
    n = 0;
    while (o_sync_oe_b !== 1'b0 && n < 20)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    n = 0;
    while (o_sync_oe_b === 1'b0 && o_sync_out === 1'b1 && n < 20)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    check("hold", 32'(n), 32'h3);
    check("rebusy", {30'h0, o_sync_oe_b, o_sync_out}, 32'h0);
    $display("test sync done");
    end_sim();
  end

  // Cuts a hung run short.
  initial
  begin
    #100us;
    num_errors++;
    end_sim();
  end
endmodule
